// >>> encoder_decoder_serial_interface.sv
`default_nettype none
// What this block does
// - Internal mode: carrier sense reaches the MAC and also drives the pin.
// - Internal decoder raises carrier on a high-to-low receive line transition.
// - Carrier stays up one and a half bit times after the last bit.
// - Internal decoder drives collision high while the collision signal toggles.
// - MAC watches collision from frame delimiter start to packet end.
// - After each transmission MAC keeps sampling collision for the heartbeat.
// - External mode: data pin is captured on each rising receive clock while the two-entry buffer has room.
// - Recovered clock keeps running five bit times after carrier drops.
// - External mode: carrier, collision, data and clock come from pins.
// - Data and clock pins float until the config register is first written.
// - Extended bus option turns shared pins into programmed user outputs.
// - User output on clock pin floats until the device first becomes master.
module encoder_decoder_serial_interface (
  input  wire logic                                clock_i,
  input  wire logic                                srst_i,
  input  wire logic                                ce_i,
  input  wire logic [encoder_decoder_serial_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [encoder_decoder_serial_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                                wr_i,
  input  wire logic                                rd_i,
  output var  logic [encoder_decoder_serial_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                                rx_line_i,
  input  wire logic                                coll_line_i,
  input  wire logic                                carrier_pin_i,
  output var  logic                                carrier_pin_o,
  output var  logic                                carrier_pin_oe_o,
  input  wire logic                                collision_pin_i,
  output var  logic                                collision_pin_o,
  output var  logic                                collision_pin_oe_o,
  input  wire logic                                recv_data_pin_i,
  output var  logic                                recv_data_pin_o,
  output var  logic                                recv_data_pin_oe_o,
  input  wire logic                                recv_clock_pin_i,
  output var  logic                                recv_clock_pin_o,
  output var  logic                                recv_clock_pin_oe_o,
  input  wire logic                                bus_master_i,
  input  wire logic                                tx_sfd_i,
  input  wire logic                                tx_active_i,
  output var  logic                                mac_carrier_o,
  output var  logic                                mac_collision_o,
  output var  logic                                mac_data_o,
  output var  logic                                mac_valid_o,
  input  wire logic                                mac_ready_i
);
  localparam int N = encoder_decoder_serial_pkg::SYNC_N;

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : fell

  function automatic logic [encoder_decoder_serial_pkg::CNT_W-1:0] dec(input logic [encoder_decoder_serial_pkg::CNT_W-1:0] v);
    return (v == '0) ? v : v - 1'b1;
  endfunction : dec

  // Synchroniser stages and edge history
  logic [N-1:0] pins;
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] sync3;
  logic [N-1:0] next_sync1;
  logic [N-1:0] next_sync2;
  logic [N-1:0] next_sync3;

  always_comb begin
    pins                               = '0;
    pins[encoder_decoder_serial_pkg::S_LINE]     = rx_line_i;
    pins[encoder_decoder_serial_pkg::S_COLL]     = coll_line_i;
    pins[encoder_decoder_serial_pkg::S_CRS_IN]   = carrier_pin_i;
    pins[encoder_decoder_serial_pkg::S_COL_IN]   = collision_pin_i;
    pins[encoder_decoder_serial_pkg::S_RXD_IN]   = recv_data_pin_i;
    pins[encoder_decoder_serial_pkg::S_RXC_IN]   = recv_clock_pin_i;
    next_sync1                         = pins;
    next_sync2                         = sync1;
    next_sync3                         = sync2;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else if (ce_i) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
    end
  end

  logic line_now;
  logic line_edge;
  logic coll_edge;
  assign line_now  = sync2[encoder_decoder_serial_pkg::S_LINE];
  assign line_edge = line_now ^ sync3[encoder_decoder_serial_pkg::S_LINE];
  assign coll_edge = sync2[encoder_decoder_serial_pkg::S_COLL] ^ sync3[encoder_decoder_serial_pkg::S_COLL];

  // Internal decoder state
  logic                              carrier;
  logic                              coll_act;
  logic                              int_clock;
  logic                              int_data;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] hold;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] tail;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] phase;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] coll_cnt;
  logic                              next_carrier;
  logic                              next_coll_act;
  logic                              next_int_clock;
  logic                              next_int_data;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] next_hold;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] next_tail;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] next_phase;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] next_coll_cnt;
  logic                              run;

  // Carrier detect, clock recovery and collision activity
  always_comb begin
    next_carrier  = carrier;
    next_hold     = hold;
    next_tail     = dec(tail);
    next_phase    = phase;
    next_int_data = int_data;
    next_coll_act = coll_act;
    next_coll_cnt = dec(coll_cnt);
    if (!carrier) begin
      if (fell(sync3[encoder_decoder_serial_pkg::S_LINE], line_now)) begin
        next_carrier = 1'b1;
        next_hold    = encoder_decoder_serial_pkg::CARRIER_HOLD_CYC - 1'b1;
        next_tail    = '0;
      end
    end else if (line_edge) begin
      next_hold = encoder_decoder_serial_pkg::CARRIER_HOLD_CYC - 1'b1;
    end else if (hold != '0) begin
      next_hold = hold - 1'b1;
    end else begin
      next_carrier = 1'b0;
      next_tail    = encoder_decoder_serial_pkg::CLOCK_TAIL_CYC;
    end
    run = next_carrier | (next_tail != '0);
    if (!run || (carrier == 1'b0 && next_carrier)) begin
      next_phase = '0;
    end else if (phase == encoder_decoder_serial_pkg::BIT_CYC - 1'b1) begin
      next_phase    = '0;
      next_int_data = line_now;
    end else begin
      next_phase = phase + 1'b1;
    end
    next_int_clock = run & (next_phase == '0);
    if (coll_edge) begin
      next_coll_act = 1'b1;
      next_coll_cnt = encoder_decoder_serial_pkg::COLL_IDLE_CYC - 1'b1;
    end else if (coll_cnt == '0) begin
      next_coll_act = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      carrier   <= 1'b0;
      coll_act  <= 1'b0;
      int_clock <= 1'b0;
      int_data  <= 1'b0;
      hold      <= '0;
      tail      <= '0;
      phase     <= '0;
      coll_cnt  <= '0;
    end else if (ce_i) begin
      carrier   <= next_carrier;
      coll_act  <= next_coll_act;
      int_clock <= next_int_clock;
      int_data  <= next_int_data;
      hold      <= next_hold;
      tail      <= next_tail;
      phase     <= next_phase;
      coll_cnt  <= next_coll_cnt;
    end
  end

  // MAC side, buffer, transmit monitor and registers
  logic [1:0]                   cfg;
  logic [1:0]                   uout;
  logic                         cfg_written;
  logic                         master_seen;
  logic                         tx_coll;
  logic                         heartbeat;
  logic                         overflow;
  logic                         prev_clock;
  logic                         e0;
  logic                         e1;
  logic                         v0;
  logic                         v1;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] hb_cnt;
  encoder_decoder_serial_pkg::tx_state_t  tx_state;
  logic [1:0]                   next_cfg;
  logic [1:0]                   next_uout;
  logic                         next_cfg_written;
  logic                         next_master_seen;
  logic                         next_tx_coll;
  logic                         next_heartbeat;
  logic                         next_overflow;
  logic                         next_e0;
  logic                         next_e1;
  logic                         next_v0;
  logic                         next_v1;
  logic [encoder_decoder_serial_pkg::CNT_W-1:0] next_hb_cnt;
  encoder_decoder_serial_pkg::tx_state_t  next_tx_state;
  logic [encoder_decoder_serial_pkg::DATA_W-1:0] next_rdata;
  logic [encoder_decoder_serial_pkg::DATA_W-1:0] status;
  encoder_decoder_serial_pkg::serial_t    sel;
  logic                         ext;
  logic                         user_pins;
  logic                         push;
  logic                         pop;
  logic                         clr;

  assign ext       = cfg[encoder_decoder_serial_pkg::CFG_EXT_BIT];
  assign user_pins = cfg[encoder_decoder_serial_pkg::CFG_USER_BIT];

  always_comb begin
    // Source select for the MAC
    if (ext) begin
      sel.carrier   = sync2[encoder_decoder_serial_pkg::S_CRS_IN];
      sel.collision = sync2[encoder_decoder_serial_pkg::S_COL_IN];
      sel.data      = sync2[encoder_decoder_serial_pkg::S_RXD_IN];
      sel.clock     = sync2[encoder_decoder_serial_pkg::S_RXC_IN];
    end else begin
      sel.carrier   = carrier;
      sel.collision = coll_act;
      sel.data      = int_data;
      sel.clock     = int_clock;
    end
    push = sel.clock & ~prev_clock;
    pop  = v0 & mac_ready_i;
    // Two-entry buffer: shift on pop, then fill first free slot
    next_e0 = pop ? e1 : e0;
    next_v0 = pop ? v1 : v0;
    next_e1 = e1;
    next_v1 = pop ? 1'b0 : v1;
    if (push && (!v1 || pop)) begin // Slot freed by a pop in this cycle is usable
      if (!next_v0) begin
        next_e0 = sel.data;
        next_v0 = 1'b1;
      end else begin
        next_e1 = sel.data;
        next_v1 = 1'b1;
      end
    end
    // Status bits: a set in the clearing cycle wins
    clr            = wr_i && (addr_i == encoder_decoder_serial_pkg::ADDR_STATUS);
    next_overflow  = (overflow & ~(clr & wdata_i[encoder_decoder_serial_pkg::ST_OVERFLOW])) | (push & v1 & ~pop);
    next_tx_coll   = tx_coll & ~(clr & wdata_i[encoder_decoder_serial_pkg::ST_TX_COLL]);
    next_heartbeat = heartbeat & ~(clr & wdata_i[encoder_decoder_serial_pkg::ST_HEARTBEAT]);
    next_hb_cnt    = dec(hb_cnt);
    next_tx_state  = tx_state;
    case (tx_state)
      encoder_decoder_serial_pkg::TX_IDLE: begin
        if (tx_sfd_i) begin
          next_tx_state = encoder_decoder_serial_pkg::TX_FRAME;
        end
      end
      encoder_decoder_serial_pkg::TX_FRAME: begin
        if (sel.collision) begin
          next_tx_coll = 1'b1;
        end
        if (!tx_active_i) begin
          next_tx_state = encoder_decoder_serial_pkg::TX_HEARTBEAT;
          next_hb_cnt   = encoder_decoder_serial_pkg::HB_WINDOW_CYC - 1'b1;
        end
      end
      encoder_decoder_serial_pkg::TX_HEARTBEAT: begin
        if (sel.collision) begin
          next_heartbeat = 1'b1;
          next_tx_state  = encoder_decoder_serial_pkg::TX_IDLE;
        end else if (tx_sfd_i) begin
          next_tx_state = encoder_decoder_serial_pkg::TX_FRAME;
        end else if (hb_cnt == '0) begin
          next_tx_state = encoder_decoder_serial_pkg::TX_IDLE;
        end
      end
      default: begin
        next_tx_state = encoder_decoder_serial_pkg::TX_IDLE;
      end
    endcase
    // Configuration registers
    next_cfg         = cfg;
    next_uout        = uout;
    next_cfg_written = cfg_written;
    next_master_seen = master_seen | bus_master_i;
    if (wr_i && addr_i == encoder_decoder_serial_pkg::ADDR_CFG) begin
      next_cfg         = wdata_i[1:0];
      next_cfg_written = 1'b1;
    end
    if (wr_i && addr_i == encoder_decoder_serial_pkg::ADDR_UOUT) begin
      next_uout = wdata_i[1:0];
    end
    status                                 = '0;
    status[encoder_decoder_serial_pkg::ST_CARRIER]   = sel.carrier;
    status[encoder_decoder_serial_pkg::ST_COLLISION] = sel.collision;
    status[encoder_decoder_serial_pkg::ST_TX_COLL]   = tx_coll;
    status[encoder_decoder_serial_pkg::ST_HEARTBEAT] = heartbeat;
    status[encoder_decoder_serial_pkg::ST_OVERFLOW]  = overflow;
    status[encoder_decoder_serial_pkg::ST_CONFIGURED] = cfg_written;
    status[encoder_decoder_serial_pkg::ST_MASTER]    = master_seen;
    next_rdata = '0;
    if (rd_i) begin
      case (addr_i)
        encoder_decoder_serial_pkg::ADDR_CFG:    next_rdata = {{(encoder_decoder_serial_pkg::DATA_W-2){1'b0}}, cfg};
        encoder_decoder_serial_pkg::ADDR_UOUT:   next_rdata = {{(encoder_decoder_serial_pkg::DATA_W-2){1'b0}}, uout};
        encoder_decoder_serial_pkg::ADDR_STATUS: next_rdata = status;
        default:                       next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cfg                 <= encoder_decoder_serial_pkg::CFG_RESET;
      uout                <= encoder_decoder_serial_pkg::UOUT_RESET;
      cfg_written         <= 1'b0;
      master_seen         <= 1'b0;
      tx_coll             <= 1'b0;
      heartbeat           <= 1'b0;
      overflow            <= 1'b0;
      prev_clock          <= 1'b0;
      e0                  <= 1'b0;
      e1                  <= 1'b0;
      v0                  <= 1'b0;
      v1                  <= 1'b0;
      hb_cnt              <= '0;
      tx_state            <= encoder_decoder_serial_pkg::TX_IDLE;
      rdata_o             <= '0;
      mac_carrier_o       <= 1'b0;
      mac_collision_o     <= 1'b0;
      carrier_pin_o       <= 1'b0;
      carrier_pin_oe_o    <= 1'b0;
      collision_pin_o     <= 1'b0;
      collision_pin_oe_o  <= 1'b0;
      recv_data_pin_o     <= 1'b0;
      recv_data_pin_oe_o  <= 1'b0;
      recv_clock_pin_o    <= 1'b0;
      recv_clock_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      cfg                 <= next_cfg;
      uout                <= next_uout;
      cfg_written         <= next_cfg_written;
      master_seen         <= next_master_seen;
      tx_coll             <= next_tx_coll;
      heartbeat           <= next_heartbeat;
      overflow            <= next_overflow;
      prev_clock          <= sel.clock;
      e0                  <= next_e0;
      e1                  <= next_e1;
      v0                  <= next_v0;
      v1                  <= next_v1;
      hb_cnt              <= next_hb_cnt;
      tx_state            <= next_tx_state;
      rdata_o             <= next_rdata;
      mac_carrier_o       <= sel.carrier;
      mac_collision_o     <= sel.collision;
      carrier_pin_o       <= carrier;
      carrier_pin_oe_o    <= ~ext;
      collision_pin_o     <= coll_act;
      collision_pin_oe_o  <= ~ext;
      recv_data_pin_o     <= user_pins ? uout[encoder_decoder_serial_pkg::UOUT_0_BIT] : int_data;
      recv_data_pin_oe_o  <= cfg_written & (user_pins | ~ext);
      recv_clock_pin_o    <= user_pins ? uout[encoder_decoder_serial_pkg::UOUT_1_BIT] : int_clock;
      recv_clock_pin_oe_o <= cfg_written & (user_pins ? master_seen : ~ext);
    end
  end

  assign mac_data_o  = e0;
  assign mac_valid_o = v0;

  // Checks
  default clocking cb @(posedge clock_i iff ce_i); endclocking
  default disable iff (srst_i);

  sequence s_carrier_hold;
    carrier [*4];
  endsequence

  AST_CRS_MIRROR: assert property (!ext |=> carrier_pin_oe_o && carrier_pin_o == $past(carrier))
    else $error("carrier pin does not mirror internal carrier");
  AST_CRS_RISE: assert property (!carrier && fell(sync3[encoder_decoder_serial_pkg::S_LINE], line_now) |=> carrier)
    else $error("carrier not raised on falling line edge");
  AST_CRS_HOLD: assert property (carrier && line_edge |=> s_carrier_hold)
    else $error("carrier dropped before hold time");
  AST_COLL_ACT: assert property (coll_edge |=> coll_act [*2])
    else $error("collision output not active on collision signal");
  AST_TX_COLL: assert property (tx_state == encoder_decoder_serial_pkg::TX_FRAME && sel.collision |=> tx_coll)
    else $error("collision during frame not recorded");
  AST_HB_WINDOW: assert property ($rose(tx_state == encoder_decoder_serial_pkg::TX_HEARTBEAT)
                                  |-> ##[1:50] tx_state != encoder_decoder_serial_pkg::TX_HEARTBEAT)
    else $error("heartbeat window overran");
  AST_EXT_CAPTURE: assert property (ext && push && !v1 && !pop |=> v0 && (v1 || e0 == $past(sel.data)))
    else $error("external data not captured on clock rise");
  AST_CLOCK_TAIL: assert property ($fell(carrier) |-> (tail != '0) [*8])
    else $error("recovered clock stopped early");
  AST_FLOAT_UNCONF: assert property (!cfg_written |-> !recv_data_pin_oe_o && !recv_clock_pin_oe_o)
    else $error("shared pin driven before configuration");
  AST_USER_OUT: assert property (user_pins && cfg_written |=> recv_data_pin_oe_o
                                 && recv_data_pin_o == $past(uout[encoder_decoder_serial_pkg::UOUT_0_BIT]))
    else $error("user output 0 wrong");
  AST_USER_CLK: assert property (user_pins && !master_seen |=> !recv_clock_pin_oe_o)
    else $error("user output 1 driven before bus master");
endmodule : encoder_decoder_serial_interface
`default_nettype wire

// >>> encoder_decoder_serial_pkg.sv
`default_nettype none
package encoder_decoder_serial_pkg;
  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 6;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CFG    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_UOUT   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;

  // Field positions
  localparam int CFG_EXT_BIT   = 0;
  localparam int CFG_USER_BIT  = 1;
  localparam int UOUT_0_BIT    = 0;
  localparam int UOUT_1_BIT    = 1;
  localparam int ST_CARRIER    = 0;
  localparam int ST_COLLISION  = 1;
  localparam int ST_TX_COLL    = 2;
  localparam int ST_HEARTBEAT  = 3;
  localparam int ST_OVERFLOW   = 4;
  localparam int ST_CONFIGURED = 5;
  localparam int ST_MASTER     = 6;

  // Reset values
  localparam logic [1:0] CFG_RESET  = 2'h0;
  localparam logic [1:0] UOUT_RESET = 2'h0;

  // Positions in the synchroniser vector
  localparam int SYNC_N    = 6;
  localparam int S_LINE    = 0;
  localparam int S_COLL    = 1;
  localparam int S_CRS_IN  = 2;
  localparam int S_COL_IN  = 3;
  localparam int S_RXD_IN  = 4;
  localparam int S_RXC_IN  = 5;

  // Timing
  localparam int CLK_NS          = 40;
  localparam int BIT_NS          = 100;
  localparam int CARRIER_HOLD_NS = 150;
  localparam int CLOCK_TAIL_NS   = 500;
  localparam int COLL_IDLE_NS    = 200;
  localparam int HB_WINDOW_NS    = 2000;
  localparam logic [CNT_W-1:0] BIT_CYC          = CNT_W'((BIT_NS + CLK_NS / 2) / CLK_NS);
  localparam logic [CNT_W-1:0] CARRIER_HOLD_CYC = CNT_W'((CARRIER_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CLOCK_TAIL_CYC   = CNT_W'((CLOCK_TAIL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] COLL_IDLE_CYC    = CNT_W'((COLL_IDLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] HB_WINDOW_CYC    = CNT_W'(HB_WINDOW_NS / CLK_NS);

  // Serial signal bundle towards the MAC
  typedef struct packed {
    logic carrier;
    logic collision;
    logic data;
    logic clock;
  } serial_t;

  typedef enum logic [2:0] {
    TX_IDLE      = 3'b001,
    TX_FRAME     = 3'b010,
    TX_HEARTBEAT = 3'b100
  } tx_state_t;
endpackage : encoder_decoder_serial_pkg
`default_nettype wire

// >>> ext_encoder_decoder_model.sv
`default_nettype none
// External encoder/decoder: link clock runs only inside a frame
module ext_encoder_decoder_model (
  output var logic carrier_o,
  output var logic data_o,
  output var logic rclk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    carrier_o = 1'b0;
    data_o    = 1'b0;
    rclk_o    = 1'b0;
  end
  // One frame of n bits, LSB first, 320 ns bit clock
  task automatic send(input logic [7:0] b, input int n);
    #13 carrier_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      data_o = b[i];
      #160 rclk_o = 1'b1;
      #160 rclk_o = 1'b0;
    end
    #37 carrier_o = 1'b0;
    data_o = ~data_o; // Released line shows no stale bit
  endtask : send
endmodule : ext_encoder_decoder_model
`default_nettype wire

// >>> mac_encoder_decoder_serial_interface_tb.sv
`default_nettype none
module mac_encoder_decoder_serial_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, srst_i, wr_i, rd_i, rx_line_i, coll_line_i, col_ext, bus_master_i, tx_sfd_i, tx_active_i;
  logic mac_ready_i, crs_p, rxd_p, rxc_p, ce_i, p6;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, v;
  logic [7:0]  po;
  logic mac_carrier_o, mac_collision_o, mac_data_o, mac_valid_o;
  logic q[$], q2[$];
  int fails, n_tests, cyc, k;
  ext_encoder_decoder_model i_encoder_decoder (.carrier_o(crs_p), .data_o(rxd_p), .rclk_o(rxc_p));
  encoder_decoder_serial_interface i_dut (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_line_i(rx_line_i),
    .coll_line_i(coll_line_i), .carrier_pin_i(crs_p), .carrier_pin_o(po[0]), .carrier_pin_oe_o(po[1]),
    .collision_pin_i(col_ext), .collision_pin_o(po[2]), .collision_pin_oe_o(po[3]),
    .recv_data_pin_i(rxd_p), .recv_data_pin_o(po[4]), .recv_data_pin_oe_o(po[5]),
    .recv_clock_pin_i(rxc_p), .recv_clock_pin_o(po[6]), .recv_clock_pin_oe_o(po[7]),
    .bus_master_i(bus_master_i), .tx_sfd_i(tx_sfd_i), .tx_active_i(tx_active_i),
    .mac_carrier_o(mac_carrier_o), .mac_collision_o(mac_collision_o), .mac_data_o(mac_data_o),
    .mac_valid_o(mac_valid_o), .mac_ready_i(mac_ready_i));
  // Clock, 40 ns period
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // MAC bits, user-side bits taken at the rising recovered clock, and the ceiling
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    p6 <= po[6];
    if (mac_valid_o === 1'b1 && mac_ready_i === 1'b1) q.push_back(mac_data_o);
    if (po[6] === 1'b1 && p6 === 1'b0) q2.push_back(po[4]);
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cycles
  task automatic wrap_up();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    {srst_i, wr_i, rd_i, rx_line_i, coll_line_i, col_ext, bus_master_i, tx_sfd_i, tx_active_i} = 9'h101;
    {addr_i, wdata_i, cyc, fails, n_tests} = '0;
    mac_ready_i = 1'b1;
    ce_i = 1'b1;
    cycles(6);
    srst_i <= 1'b0;
    rd(4'h0);
    check(v, 16'h0000);
    rd(4'hC);
    check(v, 16'h0000);
    check(po[5], 1'b0);
    check(po[7], 1'b0);
    // Internal decoder: carrier, hold and clock tail
    wr(4'h0, 16'h0000);
    cycles(2);
    check({po[7], po[5]}, 2'h3);
    for (k = 0; k < 6; k++) begin
      rx_line_i <= ~rx_line_i;
      cycles(2);
    end
    check({mac_carrier_o, po[1], po[0]}, 3'h7);
    cycles(3);
    check(mac_carrier_o, 1'b1);
    cycles(9);
    check(mac_carrier_o, 1'b0);
    k = 0;
    repeat (10) begin
      cycles(1);
      if (po[6] === 1'b1) k++;
    end
    check(k > 0, 1'b1);
    cycles(20);
    check(po[6], 1'b0);
    check(q == q2 && q.size() > 0, 1'b1);
    // Collision in frame and in heartbeat window
    tx_sfd_i <= 1'b1;
    cycles(1);
    tx_sfd_i <= 1'b0;
    repeat (8) begin
      coll_line_i <= ~coll_line_i;
      cycles(2);
    end
    check({mac_collision_o, po[2]}, 2'h3);
    cycles(10);
    rd(4'h8);
    check(v[2], 1'b1);
    check(v[3], 1'b0);
    tx_active_i <= 1'b0;
    cycles(3);
    repeat (6) begin
      coll_line_i <= ~coll_line_i;
      cycles(2);
    end
    cycles(10);
    rd(4'h8);
    check(v[3], 1'b1);
    wr(4'h8, 16'h001C);
    rd(4'h8);
    check(v[4:2], 3'h0);
    // External decoder: data on rising link clock
    wr(4'h0, 16'h0001);
    cycles(2);
    check({po[5], po[3], po[1]}, 3'h0);
    col_ext <= 1'b1;
    cycles(4);
    check(mac_collision_o, 1'b1);
    col_ext <= 1'b0;
    q.delete();
    fork
      i_encoder_decoder.send(8'hA5, 8);
      begin
        cycles(20);
        check(mac_carrier_o, 1'b1);
      end
    join
    cycles(8);
    check(q.size(), 16'h8);
    for (k = 0; k < 8; k++) if (k < q.size()) check(q[k], (8'hA5 >> k) & 8'h01);
    check(mac_carrier_o, 1'b0);
    // Stalled receiver: two bits kept, rest dropped
    mac_ready_i <= 1'b0;
    q.delete();
    i_encoder_decoder.send(8'h06, 4);
    cycles(8);
    rd(4'h8);
    check(v[4], 1'b1);
    mac_ready_i <= 1'b1;
    cycles(6);
    check(q.size(), 16'h2);
    if (q.size() == 2) check({q[0], q[1]}, 2'h1);
    check(mac_valid_o, 1'b0);
    // Extended bus: programmed user outputs
    wr(4'h4, 16'h0003);
    wr(4'h0, 16'h0003);
    cycles(2);
    check({po[5], po[4]}, 2'h3);
    check(po[7], 1'b0);
    // Low clock enable freezes state, so bus master is not latched
    ce_i <= 1'b0;
    bus_master_i <= 1'b1;
    cycles(3);
    ce_i <= 1'b1;
    bus_master_i <= 1'b0;
    cycles(3);
    check(po[7], 1'b0);
    bus_master_i <= 1'b1;
    cycles(3);
    bus_master_i <= 1'b0;
    cycles(3);
    check({po[7], po[6]}, 2'h3);
    wr(4'h4, 16'h0000);
    cycles(2);
    check({po[6], po[4]}, 2'h0);
    wrap_up();
  end
endmodule : mac_encoder_decoder_serial_interface_tb
`default_nettype wire
